/* verilog/cfcr_pkg.sv */
// Package: register map, field layout, reset values and timing of the coil front-end registers
package cfcr_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [5:0] IDX_GAIN = 6'h01;
   localparam logic [5:0] IDX_CTRL = 6'h03;
   localparam logic [5:0] IDX_STAT = 6'h04;
   localparam logic [5:0] IDX_ROUTE = 6'h10;
   localparam logic [5:0] IDX_IRQ_STS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MSK = 6'h21;
   localparam int ADDR_W = 8;
   // ==========================================================
   // Reset values
   localparam logic [15:0] RST_GAIN = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0000;
   localparam logic [15:0] RST_STAT = 16'h0000;
   localparam logic [15:0] RST_ROUTE = 16'hF249;
   // ==========================================================
   // Field positions
   localparam int GAIN_CRS_LSB = 8;
   localparam int GAIN_FIN_LSB = 0;
   localparam int CODE_W = 6;
   localparam int CTRL_EXTRAP = 15;
   localparam int CTRL_CHECK = 13;
   localparam int CTRL_TURN = 11;
   localparam int STAT_OPEN = 13;
   localparam int SEL_W = 2;
   localparam int RECT_N = 4;
   // Interrupt status bits
   localparam int IRQ_N = 4;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_OPEN = 1;
   localparam int IRQ_GAIN = 2;
   localparam int IRQ_TURN = 3;
   // ==========================================================
   // Gain loop timing and thresholds
   localparam int CLK_NS = 40;
   localparam int GAIN_PERIOD_NS = 100000;
   localparam int GAIN_PERIOD_CYC = GAIN_PERIOD_NS / CLK_NS;
   localparam int PEAK_W = 12;
   localparam logic [11:0] PEAK_HI = 12'hC00;
   localparam logic [11:0] PEAK_LO = 12'h600;
   localparam logic [5:0] CODE_MAX = 6'h3F;
   localparam logic [5:0] CODE_MIN = 6'h00;
   // ==========================================================
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LAUNCH = 2'b01,
      ST_WAIT = 2'b10
   } cfcr_state_t;
endpackage

/* verilog/cfcr_gain_if.sv */
// Interface: gain codes and update strobe between the gain loop and the register bank
interface cfcr_gain_if;
   logic [5:0] coarse_code;
   logic [5:0] fine_code;
   logic updated;
   modport loop (output coarse_code, output fine_code, output updated);
   modport regs (input coarse_code, input fine_code, input updated);
endinterface

/* verilog/cfcr_gain_loop.sv */
// Automatic amplifier gain loop for the coarse and fine receiver channels
module cfcr_gain_loop
   import cfcr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Receiver magnitudes
   input wire logic [cfcr_pkg::PEAK_W-1:0] coarse_peak,
   input wire logic [cfcr_pkg::PEAK_W-1:0] fine_peak,
   input wire logic peak_valid,
   // Codes out
   cfcr_gain_if.loop gif
);
   // ==========================================================
   // Period timer
   localparam logic [11:0] PERIOD_LAST = 12'(GAIN_PERIOD_CYC - 1);
   logic [11:0] tick_cnt;
   wire tick = (tick_cnt == PERIOD_LAST);
   wire [1:0] step;
   logic [5:0] code [2];
   logic [11:0] peak [2];
   wire [11:0] sample [2];
   assign sample[0] = coarse_peak;
   assign sample[1] = fine_peak;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         gif.updated <= 1'b0;
      end else if (ce) begin
         tick_cnt <= tick ? '0 : tick_cnt + 12'h001;
         // Only a real step counts, so a code clamped at an end raises no update
         gif.updated <= |step;
      end
   end
   // ==========================================================
   // Per channel: hold the largest magnitude, step the code once per period
   // Single steps keep the loop from hunting on a noisy peak.
   for (genvar c = 0; c < 2; c++) begin : g_ch
      wire [5:0] up = (code[c] == CODE_MAX) ? code[c] : code[c] + 6'h01;
      wire [5:0] dn = (code[c] == CODE_MIN) ? code[c] : code[c] - 6'h01;
      wire [5:0] next_code = (peak[c] > PEAK_HI) ? dn : (peak[c] < PEAK_LO) ? up : code[c];
      assign step[c] = tick && (next_code != code[c]);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            code[c] <= RST_GAIN[5:0];
            peak[c] <= '0;
         end else if (ce) begin
            if (tick) begin
               code[c] <= next_code;
               peak[c] <= '0;
            end else if (peak_valid && sample[c] > peak[c]) begin
               peak[c] <= sample[c];
            end
         end
      end
   end
   assign gif.coarse_code = code[0];
   assign gif.fine_code = code[1];
endmodule

/* verilog/cfcr_route_dec.sv */
// Coarse rectifier input routing decoder, one registered selection per rectifier
module cfcr_route_dec
   import cfcr_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Routing word and channel select
   input wire logic [15:0] route,
   input wire logic chan_sel,
   // Decoded receiver inputs, 3 bits per rectifier; reference tie flag, 1 bit per rectifier
   output logic [11:0] rect_pos_input,
   output logic [11:0] rect_neg_input,
   output logic [3:0] rect_neg_dc
);
   // ==========================================================
   for (genvar r = 0; r < RECT_N; r++) begin : g_rect
      wire [1:0] psel_code = route[4*r+2 +: SEL_W];
      wire [1:0] nsel_code = route[4*r +: SEL_W];
      wire same = (psel_code == nsel_code);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rect_pos_input[3*r +: 3] <= 3'h0;
            rect_neg_input[3*r +: 3] <= 3'h0;
            rect_neg_dc[r] <= 1'b0;
         end else if (ce) begin
            rect_pos_input[3*r +: 3] <= {chan_sel, psel_code};
            rect_neg_input[3*r +: 3] <= same ? 3'h0 : {chan_sel, nsel_code};
            rect_neg_dc[r] <= same;
         end
      end
   end

   AST_NEG_DC: assert property (@(posedge pclk) disable iff (!presetn)
      ce && route[1:0] == route[3:2] |=> rect_neg_dc[0] && rect_neg_input[2:0] == 3'h0)
      else $error("rectifier 0 negative input not tied to reference");
endmodule

/* verilog/cfcr_regs.sv */
// Coil front-end register bank: gain readback, control, status, coarse routing
module cfcr_regs
   import cfcr_pkg::*;
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [cfcr_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Receiver magnitudes for the gain loop
   input wire logic [cfcr_pkg::PEAK_W-1:0] coarse_peak,
   input wire logic [cfcr_pkg::PEAK_W-1:0] fine_peak,
   input wire logic peak_valid,
   // Applied gain codes
   output logic [5:0] coarse_amp_gain_code,
   output logic [5:0] fine_amp_gain_code,
   // Extrapolation control
   input wire logic other_gain_update,
   output logic angle_extrapolation_off,
   output logic extrapolation_hold,
   // Coil check engine
   output logic coil_check_go,
   input wire logic coil_check_done,
   input wire logic coil_check_open,
   // Turn counter
   output logic turn_count_clear,
   // Coarse routing
   input wire logic chan_sel,
   output logic [11:0] rect_pos_input,
   output logic [11:0] rect_neg_input,
   output logic [3:0] rect_neg_dc,
   // Interrupt
   output logic irq
);
   import cfcr_pkg::*;

   // ==========================================================
   // Submodules
   cfcr_gain_if gif ();

   cfcr_gain_loop u_gain (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .coarse_peak(coarse_peak),
      .fine_peak(fine_peak),
      .peak_valid(peak_valid),
      .gif(gif.loop)
   );

   logic [15:0] route;

   cfcr_route_dec u_route (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .route(route),
      .chan_sel(chan_sel),
      .rect_pos_input(rect_pos_input),
      .rect_neg_input(rect_neg_input),
      .rect_neg_dc(rect_neg_dc)
   );

   assign coarse_amp_gain_code = gif.coarse_code;
   assign fine_amp_gain_code = gif.fine_code;

   // ==========================================================
   // Address decode
   wire [5:0] idx = paddr[7:2];
   wire hit_gain = (idx == IDX_GAIN);
   wire hit_ctrl = (idx == IDX_CTRL);
   wire hit_stat = (idx == IDX_STAT);
   wire hit_route = (idx == IDX_ROUTE);
   wire hit_ists = (idx == IDX_IRQ_STS);
   wire hit_imsk = (idx == IDX_IRQ_MSK);
   wire hit = hit_gain | hit_ctrl | hit_stat | hit_route | hit_ists | hit_imsk;
   wire setup = psel && !penable;
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite && !pslverr;

   // ==========================================================
   // Register state
   logic check_run;
   logic open_flag;
   cfcr_state_t state;
   logic [IRQ_N-1:0] irq_sts;
   logic [IRQ_N-1:0] irq_msk;

   wire [15:0] gain_word = {2'b00, gif.coarse_code, 2'b00, gif.fine_code};
   wire [15:0] ctrl_word = {angle_extrapolation_off, 1'b0, check_run, 1'b0,
                            turn_count_clear, 11'h000};
   wire [15:0] stat_word = {2'b00, open_flag, 13'h0000};
   wire [15:0] rd_word = hit_gain ? gain_word :
                         hit_ctrl ? ctrl_word :
                         hit_stat ? stat_word :
                         hit_route ? route :
                         hit_ists ? {12'h000, irq_sts} :
                         hit_imsk ? {12'h000, irq_msk} : 16'h0000;

   // ==========================================================
   // APB answer: data and pready are set up in the setup cycle,
   // so an access with ce high in its setup cycle takes exactly one access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready <= setup;
         if (setup) begin
            prdata <= {16'h0000, rd_word};
            pslverr <= !hit;
         end
      end
   end

   // ==========================================================
   // Control bits
   wire wr_ctrl = wr && hit_ctrl;
   wire check_req = wr_ctrl && pwdata[CTRL_CHECK] && state == ST_IDLE;
   wire check_end = state == ST_WAIT && coil_check_done;
   // Gain register writes have no decode path on purpose.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         angle_extrapolation_off <= RST_CTRL[CTRL_EXTRAP];
         turn_count_clear <= RST_CTRL[CTRL_TURN];
         route <= RST_ROUTE;
      end else if (ce) begin
         if (wr_ctrl) begin
            angle_extrapolation_off <= pwdata[CTRL_EXTRAP];
         end
         turn_count_clear <= wr_ctrl && pwdata[CTRL_TURN];
         if (wr && hit_route) begin
            route <= pwdata[15:0];
         end
      end
   end

   // Extrapolation is held for one cycle on any gain or offset update while angle_extrapolation_off is set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         extrapolation_hold <= 1'b0;
      end else if (ce) begin
         extrapolation_hold <= angle_extrapolation_off && (gif.updated || other_gain_update);
      end
   end

   // ==========================================================
   // Coil check sequencer
   cfcr_state_t next_state;
   always_comb begin
      next_state = state;
      unique case (state)
         ST_IDLE: begin
            if (check_req) begin
               next_state = ST_LAUNCH;
            end
         end
         ST_LAUNCH: begin
            next_state = ST_WAIT;
         end
         ST_WAIT: begin
            if (coil_check_done) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         check_run <= RST_CTRL[CTRL_CHECK];
         coil_check_go <= 1'b0;
         open_flag <= RST_STAT[STAT_OPEN];
      end else if (ce) begin
         state <= next_state;
         coil_check_go <= (state == ST_IDLE) && check_req;
         if (check_req) begin
            check_run <= 1'b1;
         end else if (check_end) begin
            check_run <= 1'b0;
         end
         if (check_end) begin
            open_flag <= coil_check_open;
         end
      end
   end

   // ==========================================================
   // Interrupts: sticky, write one to clear, a new event wins over the clear
   wire [IRQ_N-1:0] irq_evt = {turn_count_clear, gif.updated,
                               check_end && coil_check_open, check_end};
   wire [IRQ_N-1:0] irq_clr = (wr && hit_ists) ? pwdata[IRQ_N-1:0] : '0;
   wire [IRQ_N-1:0] next_irq_sts = (irq_sts & ~irq_clr) | irq_evt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_sts <= '0;
         irq_msk <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         irq_sts <= next_irq_sts;
         if (wr && hit_imsk) begin
            irq_msk <= pwdata[IRQ_N-1:0];
         end
         irq <= |(next_irq_sts & irq_msk);
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_GAIN_RD_CRS: assert property (ce && setup && hit_gain |=> ##1
      prdata[15:14] == 2'b00 && prdata[13:8] == $past(gif.coarse_code, 2))
      else $error("coarse gain readback wrong");
   AST_GAIN_RD_FIN: assert property (ce && setup && hit_gain |=> ##1
      prdata[7:6] == 2'b00 && prdata[5:0] == $past(gif.fine_code, 2))
      else $error("fine gain readback wrong");
   AST_GAIN_STEP: assert property ($changed(gif.coarse_code) |->
      gif.coarse_code - $past(gif.coarse_code) == 6'h01 ||
      $past(gif.coarse_code) - gif.coarse_code == 6'h01)
      else $error("gain code moved more than one step");
   AST_EXTRAP: assert property (ce && wr_ctrl |=> angle_extrapolation_off == $past(pwdata[CTRL_EXTRAP]))
      else $error("extrapolation bit not written");
   AST_CHECK_GO: assert property (ce && check_req |=> coil_check_go && check_run ##1 !coil_check_go)
      else $error("coil check start not issued once");
   AST_CHECK_END: assert property (ce && check_end |=> !check_run && state == ST_IDLE)
      else $error("check bit not cleared at end");
   AST_TURN: assert property (ce && wr_ctrl && pwdata[CTRL_TURN] |=> turn_count_clear)
      else $error("turn clear not pulsed");
   AST_TURN_SELF: assert property (ce && turn_count_clear && !wr_ctrl |=> !turn_count_clear)
      else $error("turn clear bit stuck");
   AST_FLAG_SET: assert property (ce && check_end |=> open_flag == $past(coil_check_open))
      else $error("open flag not captured");
   AST_FLAG_HOLD: assert property (!(ce && check_end) |=> $stable(open_flag))
      else $error("open flag changed outside a check");
   AST_UNMAPPED: assert property (ce && setup && !hit |=> pslverr && pready)
      else $error("unmapped access not refused");
   // A loop step may land in the same cycle; it raises updated along with the new code
   AST_RO_GAIN: assert property (ce && acc && pwrite && hit_gain |=>
      gif.updated || $stable(gain_word))
      else $error("gain register took a write");
   AST_HOLD: assert property (ce && angle_extrapolation_off &&
      (gif.updated || other_gain_update) |=> extrapolation_hold)
      else $error("extrapolation hold missing");
   AST_NO_HOLD: assert property (ce && !angle_extrapolation_off |=> !extrapolation_hold)
      else $error("extrapolation held while enabled");
   AST_CHECK_BUSY: assert property (ce && wr_ctrl && state != ST_IDLE |=> !coil_check_go)
      else $error("second check started while busy");
   AST_CTRL_RSVD: assert property (ce && setup && hit_ctrl |=>
      prdata[14] == 1'b0 && prdata[12] == 1'b0 && prdata[10:0] == 11'h000)
      else $error("reserved control bits not zero");
   AST_STAT_RSVD: assert property (ce && setup && hit_stat |=>
      prdata[15:14] == 2'b00 && prdata[12:0] == 13'h0000)
      else $error("reserved status bits not zero");
   AST_ROUTE_WR: assert property (ce && wr && hit_route |=> route == $past(pwdata[15:0]))
      else $error("routing write lost");
   AST_IRQ_MASKED: assert property (ce && irq_msk == '0 |=> !irq)
      else $error("interrupt raised while fully masked");
   AST_TURN_IRQ: assert property (ce && turn_count_clear |=> irq_sts[IRQ_TURN])
      else $error("turn clear event not recorded");

   COV_CHECK_OPEN: cover property (check_end && coil_check_open);
   COV_IRQ: cover property ($rose(irq));
   COV_ROUTE_WR: cover property (wr && hit_route);
   COV_GAIN_UPD: cover property (gif.updated);
endmodule

/* tb/cfcr_coil_model.sv */
// Partner model: coil check engine that answers each start pulse after a set delay
module cfcr_coil_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench controls
   input wire logic [7:0] delay_cyc,
   input wire logic open_result,
   // Check handshake
   input wire logic coil_check_go,
   output logic coil_check_done,
   output logic coil_check_open
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] cnt;
   logic busy;
   // ==========================================================
   // Check engine
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 8'h00;
         busy <= 1'b0;
         coil_check_done <= 1'b0;
         coil_check_open <= 1'b0;
      end else begin
         coil_check_done <= 1'b0;
         // Result line toggles outside the done cycle, so a late sample shows up
         coil_check_open <= ~coil_check_open;
         if (coil_check_go) begin
            busy <= 1'b1;
            cnt <= delay_cyc;
         end else if (busy) begin
            if (cnt == 8'h00) begin
               busy <= 1'b0;
               coil_check_done <= 1'b1;
               coil_check_open <= open_result;
            end else begin
               cnt <= cnt - 8'h01;
            end
         end
      end
   end
endmodule

/* tb/coil_frontend_control_regs_tb.sv */
// Testbench: APB register tests of the coil front-end register bank
module coil_frontend_control_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import cfcr_pkg::*;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, peak_valid;
   logic [7:0] paddr, delay_cyc;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] coarse_peak, fine_peak, rect_pos_input, rect_neg_input;
   logic [5:0] coarse_amp_gain_code, fine_amp_gain_code;
   logic other_gain_update, angle_extrapolation_off, extrapolation_hold, coil_check_go;
   logic coil_check_done, coil_check_open, turn_count_clear, chan_sel, irq, er, open_result;
   logic [3:0] rect_neg_dc;
   logic [15:0] vals [4] = '{16'hF249, 16'h1B4E, 16'h0000, 16'hE4E4};
   int fails = 0, total_checks = 0, cyc = 0, n_go = 0, n_turn = 0, n_hold = 0, n_done = 0, h;

   cfcr_regs u_cfcr_regs (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .coarse_peak(coarse_peak), .fine_peak(fine_peak),
      .peak_valid(peak_valid), .coarse_amp_gain_code(coarse_amp_gain_code),
      .fine_amp_gain_code(fine_amp_gain_code), .other_gain_update(other_gain_update),
      .angle_extrapolation_off(angle_extrapolation_off),
      .extrapolation_hold(extrapolation_hold), .coil_check_go(coil_check_go),
      .coil_check_done(coil_check_done), .coil_check_open(coil_check_open),
      .turn_count_clear(turn_count_clear), .chan_sel(chan_sel),
      .rect_pos_input(rect_pos_input), .rect_neg_input(rect_neg_input),
      .rect_neg_dc(rect_neg_dc), .irq(irq));
   cfcr_coil_model u_cfcr_coil_model (.pclk(pclk), .presetn(presetn), .delay_cyc(delay_cyc),
      .open_result(open_result), .coil_check_go(coil_check_go),
      .coil_check_done(coil_check_done), .coil_check_open(coil_check_open));

   // ==========================================================
   // Clock, pulse counters, timeout
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (coil_check_go === 1'b1) n_go++;
      if (turn_count_clear === 1'b1) n_turn++;
      if (extrapolation_hold === 1'b1) n_hold++;
      if (coil_check_done === 1'b1) n_done++;
      if (cyc == 20000) begin
         fails++;
         give_verdict();
      end
   end

   // ==========================================================
   // Bus tasks and checks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait-state count assumed; only the bench timeout ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0000_0000);
      chk(what, rd, exp);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic wait_done(input int k);
      int n;
      n = 0;
      while (n_done < k && n < 200) begin
         @(posedge pclk);
         n++;
      end
      wt(1);
      chk("done count", n_done, k);
   endtask
   task automatic pulse_other();
      @(posedge pclk);
      other_gain_update <= 1'b1;
      @(posedge pclk);
      other_gain_update <= 1'b0;
      wt(3);
   endtask
   // Routing pins expected from the select fields: {dc, neg, pos}
   function automatic logic [31:0] route_exp(input logic [15:0] v, input logic c);
      logic [31:0] e;
      logic [1:0] p, n;
      e = 32'h0;
      for (int r = 0; r < 4; r++) begin
         p = v[4*r+2 +: 2];
         n = v[4*r +: 2];
         e[3*r +: 3] = {c, p};
         e[12+3*r +: 3] = (n == p) ? 3'h0 : {c, n};
         e[24+r] = (n == p);
      end
      return e;
   endfunction
   task automatic give_verdict();
      $display("Checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; ce = 1'b1; coarse_peak = 12'h100; fine_peak = 12'hD00; peak_valid = 1'b1;
      other_gain_update = 1'b0; chan_sel = 1'b0; delay_cyc = 8'h14; open_result = 1'b1;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rchk(8'h04, 32'h0, "gain reset");
      rchk(8'h0C, 32'h0, "control reset");
      rchk(8'h10, 32'h0, "status reset");
      rchk(8'h40, 32'h0000F249, "routing reset");
      chk("routing pins reset", {rect_neg_dc, rect_neg_input, rect_pos_input}, route_exp(16'hF249, 1'b0));
      rchk(8'h84, 32'h0, "irq mask reset");
      apb(1'b0, 8'h08, 32'h0);
      chk("unmapped error", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      apb(1'b1, 8'h04, 32'h0000FFFF);
      rchk(8'h04, 32'h0, "gain after write");
      // Every control bit set: check starts, turn clear pulses, reserved bits stay zero
      apb(1'b1, 8'h0C, 32'h0000FFFF);
      rchk(8'h0C, 32'h0000A000, "control running");
      chk("start pulses", n_go, 1);
      chk("turn pulses", n_turn, 1);
      chk("extrapolation off", {31'h0, angle_extrapolation_off}, 32'h1);
      h = n_hold;
      pulse_other();
      chk("hold pulse", n_hold - h, 1);
      apb(1'b1, 8'h0C, 32'h0000A000);
      wt(2);
      chk("start while running", n_go, 1);
      rchk(8'h10, 32'h0, "status while running");
      wait_done(1);
      rchk(8'h0C, 32'h00008000, "control after check");
      rchk(8'h10, 32'h00002000, "status open coil");
      apb(1'b0, 8'h80, 32'h0);
      chk("irq status", rd & 32'h3, 32'h3);
      chk("irq masked", {31'h0, irq}, 32'h0);
      apb(1'b1, 8'h84, 32'h3);
      wt(2);
      chk("irq raised", {31'h0, irq}, 32'h1);
      apb(1'b1, 8'h80, 32'h3);
      wt(2);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      // Second check finds all coils; flag holds until that check ends
      open_result <= 1'b0;
      apb(1'b1, 8'h0C, 32'h00002000);
      wt(2);
      chk("second start", n_go, 2);
      rchk(8'h10, 32'h00002000, "status held");
      wait_done(2);
      rchk(8'h10, 32'h0, "status clean");
      h = n_hold;
      pulse_other();
      chk("no hold when enabled", n_hold - h, 0);
      apb(1'b1, 8'h80, 32'h8);
      apb(1'b1, 8'h0C, 32'h00000800);
      wt(2);
      chk("turn clear alone", n_turn, 2);
      apb(1'b0, 8'h80, 32'h0);
      chk("turn irq status", rd & 32'h8, 32'h8);
      // Routing table with both channel selects
      for (int c = 0; c < 2; c++) begin
         foreach (vals[i]) begin
            chan_sel <= c[0];
            apb(1'b1, 8'h40, {16'h0, vals[i]});
            wt(3);
            rchk(8'h40, {16'h0, vals[i]}, "routing readback");
            chk("routing pins", {rect_neg_dc, rect_neg_input, rect_pos_input}, route_exp(vals[i], c[0]));
         end
      end
      // Two gain periods: coarse climbs by two, fine stays clamped at its floor
      h = n_hold;
      apb(1'b1, 8'h0C, 32'h00008000);
      while (cyc < 5300) @(posedge pclk);
      chk("hold on gain steps", n_hold - h, 2);
      rchk(8'h04, 32'h00000200, "gain codes");
      chk("coarse code", {26'h0, coarse_amp_gain_code}, 32'h2);
      chk("fine code", {26'h0, fine_amp_gain_code}, 32'h0);
      apb(1'b0, 8'h80, 32'h0);
      chk("gain irq status", rd & 32'h4, 32'h4);
      give_verdict();
   end
endmodule
